/* hdl/ppoc_filter.sv */
// One overcurrent filter for a single sense pin.
// Assumes a 1 ms tick pulse and a synchronous sense level.
`timescale 1ns/1ps
`default_nettype none
module ppoc_filter import ppoc_pkg::*; (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic i_tick,
  input wire logic i_enable,
  input wire logic i_sense_low,
  input wire ppoc_timing_t i_timing,
  output logic o_fault
);

  typedef enum logic [2:0] {
    PPOC_OFF = 3'b001,
    PPOC_LOCK = 3'b010,
    PPOC_WATCH = 3'b100
  } ppoc_state_t;

  ppoc_state_t state, next_state;
  logic [7:0] lock_cnt, next_lock_cnt;
  logic [3:0] low_cnt, next_low_cnt;
  logic [7:0] win_cnt, next_win_cnt;
  logic win_open, next_win_open;
  logic low_prev, next_low_prev;
  logic fault_pulse, next_fault_pulse;

  always_comb begin
    next_state = state;
    next_lock_cnt = lock_cnt;
    next_low_cnt = low_cnt;
    next_win_cnt = win_cnt;
    next_win_open = win_open;
    next_low_prev = 1'b0;
    next_fault_pulse = 1'b0;
    case (state)
      PPOC_OFF: begin
        next_lock_cnt = 8'h00;
        next_low_cnt = 4'h0;
        next_win_open = 1'b0;
        if (i_enable) begin
          next_state = PPOC_LOCK;
        end
      end
      PPOC_LOCK: begin
        // Pin ignored while supply ramps
        if (i_tick) begin
          next_lock_cnt = lock_cnt + 8'h01;
        end
        if (i_tick && lock_cnt + 8'h01 >= i_timing.lockout) begin
          next_state = PPOC_WATCH;
        end
      end
      PPOC_WATCH: begin
        // Continuous sampling while enabled
        next_low_prev = i_sense_low;
        if (!i_sense_low) begin
          next_low_cnt = 4'h0;
        end else if (i_tick && low_cnt != 4'hf) begin
          next_low_cnt = low_cnt + 4'h1;
        end
        // Single pulse width from software setting
        if (i_sense_low && low_cnt >= i_timing.min_width) begin
          next_fault_pulse = 1'b1;
        end
        // Rolling window opened by first low group
        if (win_open && i_tick) begin
          next_win_cnt = win_cnt + 8'h01;
          if (win_cnt + 8'h01 >= i_timing.double_win) begin
            next_win_open = 1'b0;
          end
        end
        if (i_sense_low && !low_prev) begin
          if (win_open) begin
            next_fault_pulse = 1'b1;
          end else begin
            next_win_open = 1'b1;
            next_win_cnt = 8'h00;
          end
        end
      end
      default: next_state = PPOC_OFF;
    endcase
    if (!i_enable) begin
      next_state = PPOC_OFF;
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state <= PPOC_OFF;
      lock_cnt <= 8'h00;
      low_cnt <= 4'h0;
      win_cnt <= 8'h00;
      win_open <= 1'b0;
      low_prev <= 1'b0;
      fault_pulse <= 1'b0;
    end else begin
      state <= next_state;
      lock_cnt <= next_lock_cnt;
      low_cnt <= next_low_cnt;
      win_cnt <= next_win_cnt;
      win_open <= next_win_open;
      low_prev <= next_low_prev;
      fault_pulse <= next_fault_pulse;
    end
  end

  assign o_fault = fault_pulse;

endmodule
`default_nettype wire

/* hdl/ppoc_top.sv */
// Downstream port power control with overcurrent sensing.
// Assumes synchronous pins, 125 MHz clock, external pin resolver.
//
// Local design decisions: strobed register access and the address map.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Each port uses one pin for power enable and overcurrent sense
// - Ganged mode: one shared pin powers and senses all ports
// - Ganged mode set only by configuration register, not other inputs
// - Ganged overcurrent sets every port flag together
// - Individual mode is the reset default
// - Power off without charge indication drives pin low and disables pull-up
// - Power on releases driver and enables pull-up
// - Short transient lows are filtered out
// - Enabled port pin is sampled continuously
// - Low lasting single-pulse width declares overcurrent
// - Two low groups within double window declare overcurrent
// - Pulse width and window come from software settings
// - Pin ignored for lockout time after power on
// - Individual mode: per-port battery charging supply indication on control pin
// - Width field 4 bits, 0 to 5 ms, upper bits reserved
// - Double window 8 bits, 1 ms steps, resets to 20 ms
// - Lockout 8 bits, 1 ms steps, resets to 10 ms
module ppoc_top import ppoc_pkg::*; #(
  parameter int PORTS = 6,
  parameter int TICK_CYCLES = PPOC_TICK_CYCLES
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_write,
  input wire logic i_read,
  output logic [7:0] o_rdata,
  input wire logic [PORTS-1:0] i_port_power_sense_pins,
  output logic [PORTS-1:0] o_port_power_sense_pins,
  output logic [PORTS-1:0] o_port_power_sense_pins_oe_n,
  output logic [PORTS-1:0] o_port_pullup_en,
  input wire logic i_shared_power_sense_pin,
  output logic o_shared_power_sense_pin,
  output logic o_shared_power_sense_pin_oe_n,
  output logic o_shared_pullup_en,
  output logic [PORTS-1:0] o_overcurrent
);

  // Refuse port counts and tick lengths the logic cannot serve
  if (PORTS < 1 || PORTS > 8 || TICK_CYCLES < 1) begin : gen_bad_params
    $error("ppoc_top: unsupported parameters");
  end

  ppoc_bus_t bus;
  ppoc_timing_t timing, next_timing;
  logic gang, next_gang;
  logic [PORTS-1:0] power, next_power;
  logic [PORTS-1:0] charge, next_charge;
  logic [PORTS-1:0] flags, next_flags;
  logic [7:0] rdata, next_rdata;
  logic [31:0] tick_cnt, next_tick_cnt;
  logic tick, next_tick;
  logic [PORTS-1:0] fault;
  logic gang_fault;

  function automatic logic [7:0] ppoc_pad(input logic [PORTS-1:0] v);
    logic [7:0] r;
    r = 8'h00;
    r[PORTS-1:0] = v;
    return r;
  endfunction

  assign bus = '{addr: i_addr, wdata: i_wdata, write: i_write, read: i_read};

  // Common 1 ms tick
  always_comb begin
    next_tick = 1'b0;
    next_tick_cnt = tick_cnt + 32'd1;
    if (tick_cnt >= 32'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 32'd0;
      next_tick = 1'b1;
    end
  end

  always_comb begin
    next_timing = timing;
    next_gang = gang;
    next_power = power;
    next_charge = charge;
    next_rdata = 8'h00;
    // Latched per-port flags, hardware set wins over clear
    next_flags = flags;
    if (bus.write) begin
      case (bus.addr)
        PPOC_ADDR_MIN_WIDTH: begin
          // Codes above five saturate; reserved bits dropped
          if (bus.wdata[3:0] > PPOC_MIN_WIDTH_MAX) begin
            next_timing.min_width = PPOC_MIN_WIDTH_MAX;
          end else begin
            next_timing.min_width = bus.wdata[3:0];
          end
        end
        PPOC_ADDR_DOUBLE_WIN: begin
          // Zero never accepted
          if (bus.wdata != 8'h00) begin
            next_timing.double_win = bus.wdata;
          end
        end
        PPOC_ADDR_LOCKOUT: begin
          // Zero never accepted
          if (bus.wdata != 8'h00) begin
            next_timing.lockout = bus.wdata;
          end
        end
        // Mode only via configuration register
        PPOC_ADDR_CTRL: next_gang = bus.wdata[PPOC_CTRL_GANG_BIT];
        PPOC_ADDR_POWER: next_power = bus.wdata[PORTS-1:0];
        PPOC_ADDR_FLAGS: next_flags = flags & ~bus.wdata[PORTS-1:0];
        PPOC_ADDR_CHARGE: next_charge = bus.wdata[PORTS-1:0];
        default: next_rdata = 8'h00;
      endcase
    end
    // Ganged fault flags all ports
    if (gang) begin
      next_flags = next_flags | {PORTS{gang_fault}};
    end else begin
      next_flags = next_flags | fault;
    end
    if (bus.read) begin
      case (bus.addr)
        PPOC_ADDR_MIN_WIDTH: next_rdata = {4'h0, timing.min_width};
        PPOC_ADDR_DOUBLE_WIN: next_rdata = timing.double_win;
        PPOC_ADDR_LOCKOUT: next_rdata = timing.lockout;
        PPOC_ADDR_CTRL: next_rdata = {7'h00, gang};
        PPOC_ADDR_POWER: next_rdata = ppoc_pad(power);
        PPOC_ADDR_FLAGS: next_rdata = ppoc_pad(flags);
        PPOC_ADDR_PIN: next_rdata = ppoc_pad(i_port_power_sense_pins);
        PPOC_ADDR_CHARGE: next_rdata = ppoc_pad(charge);
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      timing <= '{min_width: PPOC_MIN_WIDTH_RST,
                  double_win: PPOC_DOUBLE_WIN_RST,
                  lockout: PPOC_LOCKOUT_RST};
      gang <= 1'b0; // Individual mode default
      power <= '0;
      charge <= '0;
      flags <= '0;
      rdata <= 8'h00;
      tick_cnt <= 32'd0;
      tick <= 1'b0;
    end else begin
      timing <= next_timing;
      gang <= next_gang;
      power <= next_power;
      charge <= next_charge;
      flags <= next_flags;
      rdata <= next_rdata;
      tick_cnt <= next_tick_cnt;
      tick <= next_tick;
    end
  end

  // Per-port filters on each combined pin
  genvar g;
  generate
    for (g = 0; g < PORTS; g++) begin : gen_port
      ppoc_filter u_filter (
        .i_clock(i_clock),
        .i_nrst(i_nrst),
        .i_tick(tick),
        .i_enable(power[g] && !gang),
        .i_sense_low(!i_port_power_sense_pins[g]),
        .i_timing(timing),
        .o_fault(fault[g])
      );
    end
  endgenerate

  // Shared pin filter for ganged mode
  ppoc_filter u_gang_filter (
    .i_clock(i_clock),
    .i_nrst(i_nrst),
    .i_tick(tick),
    .i_enable(power[0] && gang),
    .i_sense_low(!i_shared_power_sense_pin),
    .i_timing(timing),
    .o_fault(gang_fault)
  );

  // Off drives low, no pull-up; on releases with pull-up
  // In individual mode, charge indication releases pin of unpowered port
  always_comb begin
    o_port_power_sense_pins = '0;
    o_port_power_sense_pins_oe_n = gang ? '0 : (power | charge);
    o_port_pullup_en = gang ? '0 : (power | charge);
    o_shared_power_sense_pin = 1'b0;
    o_shared_power_sense_pin_oe_n = gang & power[0];
    o_shared_pullup_en = gang & power[0];
  end

  assign o_rdata = rdata;
  assign o_overcurrent = flags;

endmodule
`default_nettype wire

/* inc/ppoc_pkg.sv */
// Package for the port power and overcurrent control block.
// Assumes a single 125 MHz clock domain and a plain register port.
package ppoc_pkg;

  localparam int PPOC_CLK_PERIOD_PS = 8000;
  localparam int PPOC_TICK_PERIOD_NS = 1000000;
  localparam int PPOC_TICK_CYCLES = PPOC_TICK_PERIOD_NS * 1000 / PPOC_CLK_PERIOD_PS;

  localparam logic [7:0] PPOC_ADDR_MIN_WIDTH = 8'hea;
  localparam logic [7:0] PPOC_ADDR_DOUBLE_WIN = 8'heb;
  localparam logic [7:0] PPOC_ADDR_LOCKOUT = 8'he1;
  localparam logic [7:0] PPOC_ADDR_CTRL = 8'h00;
  localparam logic [7:0] PPOC_ADDR_POWER = 8'h04;
  localparam logic [7:0] PPOC_ADDR_FLAGS = 8'h08;
  localparam logic [7:0] PPOC_ADDR_PIN = 8'h0c;
  localparam logic [7:0] PPOC_ADDR_CHARGE = 8'h10;

  localparam logic [3:0] PPOC_MIN_WIDTH_RST = 4'h1;
  localparam logic [3:0] PPOC_MIN_WIDTH_MAX = 4'h5;
  localparam logic [7:0] PPOC_DOUBLE_WIN_RST = 8'h14;
  localparam logic [7:0] PPOC_LOCKOUT_RST = 8'h0a;
  localparam int PPOC_CTRL_GANG_BIT = 0;

  typedef struct packed {
    logic [3:0] min_width;
    logic [7:0] double_win;
    logic [7:0] lockout;
  } ppoc_timing_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic write;
    logic read;
  } ppoc_bus_t;

endpackage

/* tb/ppoc_props.sv */
// Checker for the port power block, bound to its top.
// Assumes one clock domain and an active low reset.
`timescale 1ns/1ps
`default_nettype none
module ppoc_props import ppoc_pkg::*; #(
  parameter int PORTS = 6
) (
  input wire logic i_clock,
  input wire logic i_nrst,
  input wire logic [7:0] i_addr,
  input wire logic i_write,
  input wire logic i_read,
  input wire logic [7:0] o_rdata,
  input wire logic [PORTS-1:0] o_port_power_sense_pins,
  input wire logic [PORTS-1:0] o_port_power_sense_pins_oe_n,
  input wire logic [PORTS-1:0] o_port_pullup_en,
  input wire logic o_shared_power_sense_pin,
  input wire logic o_shared_power_sense_pin_oe_n,
  input wire logic o_shared_pullup_en,
  input wire logic [PORTS-1:0] o_overcurrent
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);
  sequence s_flag_rise;
    (o_overcurrent & ~$past(o_overcurrent)) != '0;
  endsequence
  sequence s_indiv_steady;
    !o_shared_power_sense_pin_oe_n && !$past(o_shared_power_sense_pin_oe_n, 8);
  endsequence
  chk_off_pullup: assert property (
    (~o_port_power_sense_pins_oe_n & o_port_pullup_en) == '0)
    else $error("pull-up on while pin driven");
  chk_drive_zero: assert property (
    o_port_power_sense_pins == '0 && !o_shared_power_sense_pin)
    else $error("pin driven high");
  chk_shared_pair: assert property (
    o_shared_power_sense_pin_oe_n == o_shared_pullup_en)
    else $error("shared pin release and pull-up differ");
  chk_gang_ports: assert property (
    o_shared_power_sense_pin_oe_n |-> o_port_power_sense_pins_oe_n == '0)
    else $error("port pin released in ganged mode");
  chk_rdata_idle: assert property (
    !i_read |=> o_rdata == 8'h00)
    else $error("read data without read");
  chk_flag_sticky: assert property (
    (o_overcurrent & $past(o_overcurrent)) != $past(o_overcurrent)
    |-> $past(i_write) && $past(i_addr) == PPOC_ADDR_FLAGS)
    else $error("flag dropped without clear");
  chk_gang_all: assert property (
    s_flag_rise ##0 o_shared_power_sense_pin_oe_n |-> &o_overcurrent)
    else $error("ganged fault missed a port");
  chk_lockout: assert property (
    s_flag_rise ##0 s_indiv_steady |-> (o_overcurrent & ~$past(o_overcurrent)
    & ~$past(o_port_power_sense_pins_oe_n, 8)) == '0)
    else $error("flag on freshly powered port");
endmodule
bind ppoc_top ppoc_props #(.PORTS(PORTS)) ppoc_props_inst (
  .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_write(i_write),
  .i_read(i_read), .o_rdata(o_rdata),
  .o_port_power_sense_pins(o_port_power_sense_pins),
  .o_port_power_sense_pins_oe_n(o_port_power_sense_pins_oe_n),
  .o_port_pullup_en(o_port_pullup_en),
  .o_shared_power_sense_pin(o_shared_power_sense_pin),
  .o_shared_power_sense_pin_oe_n(o_shared_power_sense_pin_oe_n),
  .o_shared_pullup_en(o_shared_pullup_en), .o_overcurrent(o_overcurrent));
`default_nettype wire

/* tb/ppoc_switch.sv */
// Model of the external power switch or fuse on each pin.
// Assumes the bench raises i_fault to stand for an overcurrent.
`timescale 1ns/1ps
`default_nettype none
module ppoc_switch #(
  parameter int N = 6
) (
  input wire logic [N-1:0] i_oe_n,
  input wire logic [N-1:0] i_pullup_en,
  input wire logic [N-1:0] i_fault,
  output logic [N-1:0] o_level
);
  // Pin low when driven, faulted or not pulled up
  assign o_level = i_oe_n & i_pullup_en & ~i_fault;
endmodule
`default_nettype wire

/* tb/ppoc_top_tb.sv */
// Bench for the port power block over its register port.
// Assumes a 10 cycle tick and the switch model on every pin.
`timescale 1ns/1ps
`default_nettype none
module ppoc_top_tb import ppoc_pkg::*;;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic i_write = 1'b0;
  logic i_read = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic [7:0] o_rdata;
  logic [5:0] pins, pin_out, oe_n, pu, oc;
  logic [5:0] fault = 6'h00;
  logic sh_lvl, sh_out, sh_oe_n, sh_pu;
  logic sh_fault = 1'b0;
  int fails = 0;
  int checks = 0;
  int cycles = 0;
  always #4 i_clock = ~i_clock;
  ppoc_top #(.PORTS(6), .TICK_CYCLES(10)) ppoc_top_inst (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_write(i_write), .i_read(i_read), .o_rdata(o_rdata),
    .i_port_power_sense_pins(pins), .o_port_power_sense_pins(pin_out),
    .o_port_power_sense_pins_oe_n(oe_n), .o_port_pullup_en(pu),
    .i_shared_power_sense_pin(sh_lvl), .o_shared_power_sense_pin(sh_out),
    .o_shared_power_sense_pin_oe_n(sh_oe_n), .o_shared_pullup_en(sh_pu),
    .o_overcurrent(oc));
  ppoc_switch #(.N(6)) ppoc_switch_inst (.i_oe_n(oe_n), .i_pullup_en(pu),
    .i_fault(fault), .o_level(pins));
  ppoc_switch #(.N(1)) ppoc_switch_shared_inst (.i_oe_n(sh_oe_n),
    .i_pullup_en(sh_pu), .i_fault(sh_fault), .o_level(sh_lvl));
  task automatic summarize;
    $display("checks=%0d fails=%0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    #1 chk(o_rdata, e);
  endtask
  task automatic pulse(input logic [5:0] p, input logic s, input int n);
    @(posedge i_clock);
    fault <= p;
    sh_fault <= s;
    cyc(n);
    fault <= 6'h00;
    sh_fault <= 1'b0;
  endtask
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      fails++;
      $display("[ERR] %0t run did not finish", $time);
      summarize;
    end
  end
  initial begin
    cyc(16);
    i_nrst <= 1'b1;
    #1 chk({2'b00, oe_n | pu}, 8'h00);
    rd(PPOC_ADDR_MIN_WIDTH, 8'h01);
    rd(PPOC_ADDR_DOUBLE_WIN, 8'h14);
    rd(PPOC_ADDR_LOCKOUT, 8'h0a);
    rd(PPOC_ADDR_CTRL, 8'h00);
    rd(8'h20, 8'h00);
    wr(PPOC_ADDR_MIN_WIDTH, 8'h0f);
    rd(PPOC_ADDR_MIN_WIDTH, 8'h05);
    wr(PPOC_ADDR_DOUBLE_WIN, 8'h00);
    rd(PPOC_ADDR_DOUBLE_WIN, 8'h14);
    wr(PPOC_ADDR_LOCKOUT, 8'h00);
    rd(PPOC_ADDR_LOCKOUT, 8'h0a);
    wr(PPOC_ADDR_MIN_WIDTH, 8'h02);
    wr(PPOC_ADDR_DOUBLE_WIN, 8'h05);
    wr(PPOC_ADDR_LOCKOUT, 8'h02);
    wr(PPOC_ADDR_POWER, 8'h01);
    #1 chk({2'b00, oe_n & pu}, 8'h01);
    pulse(6'h01, 1'b0, 5);
    cyc(30);
    rd(PPOC_ADDR_PIN, 8'h01);
    chk({2'b00, oc}, 8'h00);
    pulse(6'h01, 1'b0, 3);
    cyc(80);
    #1 chk({2'b00, oc}, 8'h00);
    pulse(6'h01, 1'b0, 3);
    cyc(10);
    pulse(6'h01, 1'b0, 3);
    cyc(5);
    rd(PPOC_ADDR_FLAGS, 8'h01);
    wr(PPOC_ADDR_FLAGS, 8'h01);
    rd(PPOC_ADDR_FLAGS, 8'h00);
    cyc(80);
    pulse(6'h01, 1'b0, 40);
    cyc(3);
    #1 chk({2'b00, oc}, 8'h01);
    wr(PPOC_ADDR_FLAGS, 8'h01);
    wr(PPOC_ADDR_POWER, 8'h00);
    #1 chk({2'b00, oe_n | pu}, 8'h00);
    wr(PPOC_ADDR_CHARGE, 8'h02);
    #1 chk({2'b00, oe_n & pu}, 8'h02);
    wr(PPOC_ADDR_CHARGE, 8'h00);
    wr(PPOC_ADDR_CTRL, 8'h01);
    wr(PPOC_ADDR_POWER, 8'h01);
    cyc(30);
    #1 chk({1'b0, oe_n, sh_oe_n}, 8'h01);
    pulse(6'h00, 1'b1, 40);
    cyc(3);
    rd(PPOC_ADDR_FLAGS, 8'h3f);
    summarize;
  end
endmodule
`default_nettype wire
